// *** design/buck_fault_hiccup_controller.sv ***
// Purpose: Fault sequencer with hiccup retry and low-side current limiting
// Assumes: Comparator results arrive asynchronous; lower gate state sensed
// Notes: Switching period derived from the system clock by a divider
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ns
module buck_fault_hiccup_controller (
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic FB_OV_IN,
  input wire logic FB_UV_IN,
  input wire logic LS_OC_IN,
  input wire logic EXT_OT_IN,
  input wire logic DIE_OT_IN,
  input wire logic LIMIT_RES_PRESENT_IN,
  input wire logic LS_GATE_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  output logic UPPER_EN_OUT,
  output logic LOWER_EN_OUT,
  output logic LOWER_FORCE_OUT,
  output logic PG_OUT,
  output logic PG_OE_N_OUT,
  output logic COMP_PULL_OUT,
  output logic SS_ACTIVE_OUT,
  output logic THRESH_FIXED_OUT,
  output buck_fault_pkg::state_t STATE_OUT
);
  import buck_fault_pkg::*;

  // ==========================================================
  // Input synchronisers
  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] s1_r;
  logic [SYNC_W-1:0] s2_r;
  logic [SYNC_W-1:0] s3_r;
  logic [SYNC_W-1:0] clean_r;

  assign raw = {LS_GATE_IN, LIMIT_RES_PRESENT_IN, DIE_OT_IN, EXT_OT_IN,
                LS_OC_IN, FB_UV_IN, FB_OV_IN};

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      clean_r <= '0;
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // Change accepted once stages two and three agree
      clean_r <= (s2_r & s3_r) | (clean_r & (s2_r | s3_r)); // RULE21
    end
  end

  // ==========================================================
  // Switching-cycle tick
  logic [7:0] sw_div_r;
  logic tick_r;

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      sw_div_r <= '0;
      tick_r <= 1'b0;
    end else if (sw_div_r == 8'(SW_PERIOD_CYC - 1)) begin
      sw_div_r <= '0;
      tick_r <= 1'b1; // RULE21
    end else begin
      sw_div_r <= sw_div_r + 8'h01;
      tick_r <= 1'b0;
    end
  end

  // ==========================================================
  // Registers
  logic ctrl_run_r;
  logic [15:0] ss_len_r;
  logic [FLT_W-1:0] fault_r;
  logic [FLT_W-1:0] fault_set;
  logic [FLT_W-1:0] fault_clr;
  logic apb_access;
  logic apb_wr;
  logic addr_ok;
  logic [31:0] rd_val;

  state_t state_r;
  state_t state_nxt;
  logic skip_r;
  logic [1:0] oc_cnt_r;
  logic [2:0] backup_r;
  logic pg_drive_r;

  assign apb_access = PSEL_IN & PENABLE_IN;
  assign apb_wr = apb_access & PREADY_OUT & PWRITE_IN & addr_ok;
  assign addr_ok = (PADDR_IN == ADDR_CTRL) || (PADDR_IN == ADDR_SS_LEN) ||
                   (PADDR_IN == ADDR_STATUS) || (PADDR_IN == ADDR_FAULT) ||
                   (PADDR_IN == ADDR_OC_CNT);
  assign fault_clr = (apb_wr && PADDR_IN == ADDR_FAULT) ? PWDATA_IN[FLT_W-1:0] : '0;

  always_comb begin
    rd_val = '0;
    case (PADDR_IN)
      ADDR_CTRL: rd_val[CTRL_RUN_BIT] = ctrl_run_r;
      ADDR_SS_LEN: rd_val[15:0] = ss_len_r;
      ADDR_STATUS: begin
        rd_val[SYNC_W-1:0] = clean_r;
        rd_val[STAT_STATE_LSB +: 7] = state_r;
        rd_val[STAT_PG_BIT] = ~pg_drive_r;
        rd_val[STAT_SKIP_BIT] = skip_r;
      end
      ADDR_FAULT: rd_val[FLT_W-1:0] = fault_r;
      ADDR_OC_CNT: rd_val[5:0] = {1'b0, backup_r, oc_cnt_r};
      default: rd_val = '0;
    endcase
  end

  // Answer one cycle into the access phase
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      PREADY_OUT <= 1'b0;
      PRDATA_OUT <= '0;
      PSLVERR_OUT <= 1'b0;
    end else begin
      PREADY_OUT <= apb_access & ~PREADY_OUT;
      if (apb_access & ~PREADY_OUT) begin
        PRDATA_OUT <= PWRITE_IN ? 32'h0000_0000 : rd_val;
        PSLVERR_OUT <= ~addr_ok;
      end else begin
        PSLVERR_OUT <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      ctrl_run_r <= CTRL_RUN_RST;
      ss_len_r <= SS_LEN_RST;
    end else if (apb_wr && PADDR_IN == ADDR_CTRL) begin
      ctrl_run_r <= PWDATA_IN[CTRL_RUN_BIT];
    end else if (apb_wr && PADDR_IN == ADDR_SS_LEN) begin
      ss_len_r <= PWDATA_IN[15:0];
    end
  end

  // Sticky fault record, set wins over write-one-to-clear
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      fault_r <= '0;
    end else begin
      fault_r <= fault_set | (fault_r & ~fault_clr);
    end
  end

  // ==========================================================
  // Low-side current blanking and trip
  logic ls_gate_d_r;
  logic [4:0] blank_cnt_r;
  logic blank_done;
  logic oc_armed;
  logic trip_now;
  logic cyc_trip_r;
  logic oc_event;
  logic oc_limit;
  logic backup_done;

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      ls_gate_d_r <= 1'b0;
      blank_cnt_r <= '0;
    end else begin
      ls_gate_d_r <= clean_r[SY_LSG];
      if (clean_r[SY_LSG] & ~ls_gate_d_r) begin
        blank_cnt_r <= '0; // RULE9
      end else if (clean_r[SY_LSG] && blank_cnt_r != 5'(LS_BLANK_CYC)) begin
        blank_cnt_r <= blank_cnt_r + 5'h01;
      end
    end
  end

  assign blank_done = clean_r[SY_LSG] & ls_gate_d_r &
                      (blank_cnt_r == 5'(LS_BLANK_CYC)); // RULE9
  assign oc_armed = (state_r == ST_SOFT) || (state_r == ST_RUN); // RULE19
  assign trip_now = oc_armed & blank_done & clean_r[SY_OC];
  assign oc_event = trip_now & ~cyc_trip_r;
  assign oc_limit = oc_event && oc_cnt_r == 2'(OC_TRIP_LIMIT - 1); // RULE12
  assign backup_done = tick_r & ~cyc_trip_r &
                       (backup_r == 3'(OC_CLEAR_CYCLES - 1)); // RULE13

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      cyc_trip_r <= 1'b0;
    end else begin
      cyc_trip_r <= trip_now | (cyc_trip_r & ~tick_r);
    end
  end

  // Upper held off until trip clears, released on a cycle boundary
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      skip_r <= 1'b0;
    end else if (!oc_armed) begin
      skip_r <= 1'b0;
    end else if (trip_now) begin
      skip_r <= 1'b1; // RULE11
    end else if (tick_r & ~clean_r[SY_OC]) begin
      skip_r <= 1'b0; // RULE11
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      oc_cnt_r <= '0;
    end else if (!oc_armed) begin
      oc_cnt_r <= '0;
    end else if (oc_event) begin
      if (oc_cnt_r != 2'(OC_TRIP_LIMIT)) begin
        oc_cnt_r <= oc_cnt_r + 2'h1; // RULE12
      end
    end else if (backup_done) begin
      oc_cnt_r <= '0; // RULE13
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      backup_r <= '0;
    end else if (!oc_armed || oc_event) begin
      backup_r <= '0; // RULE14
    end else if (tick_r) begin
      if (cyc_trip_r || backup_done) begin
        backup_r <= '0;
      end else begin
        backup_r <= backup_r + 3'h1; // RULE13
      end
    end
  end

  // ==========================================================
  // Voltage fault blanking timers
  logic [11:0] ov_cnt_r;
  logic [11:0] uv_cnt_r;
  logic ov_fault;
  logic uv_fault;
  logic in_run;

  assign in_run = (state_r == ST_RUN); // RULE3
  assign ov_fault = in_run & clean_r[SY_OV] & (ov_cnt_r == 12'(OV_BLANK_CYC)); // RULE6
  assign uv_fault = in_run & clean_r[SY_UV] & (uv_cnt_r == 12'(UV_BLANK_CYC)); // RULE8

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      ov_cnt_r <= '0;
    end else if (!(in_run & clean_r[SY_OV])) begin
      ov_cnt_r <= '0;
    end else if (ov_cnt_r != 12'(OV_BLANK_CYC)) begin
      ov_cnt_r <= ov_cnt_r + 12'h001; // RULE20
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      uv_cnt_r <= '0;
    end else if (!(in_run & clean_r[SY_UV])) begin
      uv_cnt_r <= '0;
    end else if (uv_cnt_r != 12'(UV_BLANK_CYC)) begin
      uv_cnt_r <= uv_cnt_r + 12'h001; // RULE20
    end
  end

  // ==========================================================
  // Sequencer
  logic [17:0] seq_cnt_r;
  logic ss_end;
  logic hiccup_end;

  assign ss_end = seq_cnt_r >= {2'b00, ss_len_r};
  assign hiccup_end = seq_cnt_r >= 18'({2'b00, ss_len_r} * 18'(HICCUP_SS_MULT)); // RULE2

  always_comb begin
    state_nxt = state_r;
    fault_set = '0;
    if (!ctrl_run_r) begin
      state_nxt = ST_OFF;
    end else begin
      case (state_r)
        ST_OFF: state_nxt = ST_SOFT;
        ST_SOFT: begin
          if (oc_limit) begin
            state_nxt = ST_HICCUP; // RULE3
            fault_set[FLT_OC] = 1'b1;
          end else if (ss_end) begin
            state_nxt = ST_RUN;
          end
        end
        ST_RUN: begin
          if (clean_r[SY_DIE]) begin
            state_nxt = ST_DIE_OT; // RULE15
            fault_set[FLT_DIE] = 1'b1;
          end else if (clean_r[SY_EXT]) begin
            state_nxt = ST_EXT_OT; // RULE4
            fault_set[FLT_EXT] = 1'b1;
          end else if (ov_fault) begin
            state_nxt = ST_OV_DIS; // RULE6
            fault_set[FLT_OV] = 1'b1;
          end else if (uv_fault) begin
            state_nxt = ST_HICCUP; // RULE8
            fault_set[FLT_UV] = 1'b1;
          end else if (oc_limit) begin
            state_nxt = ST_HICCUP; // RULE12
            fault_set[FLT_OC] = 1'b1;
          end
        end
        ST_OV_DIS: begin
          if (clean_r[SY_UV]) begin
            state_nxt = ST_HICCUP; // RULE7
          end
        end
        ST_HICCUP: begin
          if (hiccup_end) begin
            state_nxt = ST_SOFT; // RULE2
          end
        end
        ST_EXT_OT: begin
          if (!clean_r[SY_EXT]) begin
            state_nxt = ST_SOFT; // RULE5
          end
        end
        ST_DIE_OT: begin
          if (!clean_r[SY_DIE]) begin
            state_nxt = ST_SOFT; // RULE16
          end
        end
        default: state_nxt = ST_OFF;
      endcase
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      state_r <= ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Ticks spent in soft-start or hiccup wait
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN || state_nxt != state_r) begin
      seq_cnt_r <= '0;
    end else if (tick_r && seq_cnt_r != 18'h3ffff) begin
      seq_cnt_r <= seq_cnt_r + 18'h00001; // RULE20
    end
  end

  // ==========================================================
  // Outputs
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      UPPER_EN_OUT <= 1'b0;
      LOWER_EN_OUT <= 1'b0;
      LOWER_FORCE_OUT <= 1'b0;
      PG_OUT <= 1'b0;
      pg_drive_r <= 1'b1;
      PG_OE_N_OUT <= 1'b0;
      COMP_PULL_OUT <= 1'b0;
      SS_ACTIVE_OUT <= 1'b0;
      THRESH_FIXED_OUT <= 1'b0;
      STATE_OUT <= ST_OFF;
    end else begin
      UPPER_EN_OUT <= oc_armed & ~skip_r & ~trip_now; // RULE1 RULE11
      LOWER_EN_OUT <= oc_armed | (state_r == ST_OV_DIS); // RULE1 RULE4 RULE15
      LOWER_FORCE_OUT <= (state_r == ST_OV_DIS); // RULE6
      PG_OUT <= 1'b0;
      pg_drive_r <= !(in_run & ~clean_r[SY_OV] & ~clean_r[SY_UV] & ~skip_r &
                      ~clean_r[SY_EXT] & ~clean_r[SY_DIE]); // RULE18
      PG_OE_N_OUT <= !(in_run & ~clean_r[SY_OV] & ~clean_r[SY_UV] & ~skip_r &
                       ~clean_r[SY_EXT] & ~clean_r[SY_DIE]) ? 1'b0 : 1'b1; // RULE17
      COMP_PULL_OUT <= (state_r == ST_DIE_OT) |
                       ((state_r == ST_SOFT) & (seq_cnt_r == 18'h00000)); // RULE16
      SS_ACTIVE_OUT <= (state_r == ST_SOFT);
      THRESH_FIXED_OUT <= ~clean_r[SY_RES]; // RULE10
      STATE_OUT <= state_r;
    end
  end

endmodule

// *** design/buck_fault_pkg.sv ***
// Purpose: Constants and types for the converter fault sequencer
// Assumes: 100 MHz system clock, APB register access
// Notes: Timing counts are in system clock cycles
// Function
// RULE1 - Entering hiccup turns both switches off and pulls the flag low
// RULE2 - Hiccup waits four soft-start periods, then starts a new soft-start
// RULE3 - Soft-start after hiccup arms only over-current detection
// RULE4 - External over-temperature high stops switching, both switches off
// RULE5 - External over-temperature clearing starts a new soft-start automatically
// RULE6 - Over-voltage held over 20 us sets fault: upper off, lower on, flag low
// RULE7 - Over-voltage fault keeps lower on until under-voltage, then hiccup
// RULE8 - Under-voltage held over 20 us sets fault and enters hiccup
// RULE9 - Low-side current trip ignored for 150 ns after lower switch turns on
// RULE10 - No limit resistor detected selects fixed 300 mV current threshold
// RULE11 - After current trip, upper stays off until trip clears, next cycle resumes
// RULE12 - Third consecutive over-current event enters hiccup
// RULE13 - Seven trip-free switching cycles clear the over-current event count
// RULE14 - Backup counter restarts on every current trip until third count
// RULE15 - Die over-temperature turns both switches off
// RULE16 - Die over-temperature clearing pulls compensation low and starts soft-start
// RULE17 - Flag released while output within limits and nothing else pulls it
// RULE18 - Flag low in soft-start and during any fault condition
// RULE19 - During any soft-start only over-current detection is active
// RULE20 - Fault blanking and hiccup wait timed by clock counters
// RULE21 - Comparator inputs synchronised; switching tick paces current counters
package buck_fault_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int OV_BLANK_NS = 20000;
  localparam int UV_BLANK_NS = 20000;
  localparam int LS_BLANK_NS = 150;
  localparam int SW_PERIOD_NS = 2000;
  localparam int OV_BLANK_CYC = (OV_BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam int UV_BLANK_CYC = (UV_BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam int LS_BLANK_CYC = (LS_BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam int SW_PERIOD_CYC = (SW_PERIOD_NS * CLK_MHZ) / 1000;
  localparam int HICCUP_SS_MULT = 4;
  localparam int OC_TRIP_LIMIT = 3;
  localparam int OC_CLEAR_CYCLES = 7;

  // ==========================================================
  // Synchroniser bit positions
  localparam int SYNC_W = 7;
  localparam int SY_OV = 0;
  localparam int SY_UV = 1;
  localparam int SY_OC = 2;
  localparam int SY_EXT = 3;
  localparam int SY_DIE = 4;
  localparam int SY_RES = 5;
  localparam int SY_LSG = 6;

  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SS_LEN = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_FAULT = 8'h0c;
  localparam logic [7:0] ADDR_OC_CNT = 8'h10;
  localparam int CTRL_RUN_BIT = 0;
  localparam logic CTRL_RUN_RST = 1'b1;
  localparam logic [15:0] SS_LEN_RST = 16'h01f4;
  localparam int FLT_OV = 0;
  localparam int FLT_UV = 1;
  localparam int FLT_OC = 2;
  localparam int FLT_EXT = 3;
  localparam int FLT_DIE = 4;
  localparam int FLT_W = 5;
  localparam int STAT_STATE_LSB = 8;
  localparam int STAT_PG_BIT = 16;
  localparam int STAT_SKIP_BIT = 17;

  typedef enum logic [6:0] {
    ST_OFF = 7'h01,
    ST_SOFT = 7'h02,
    ST_RUN = 7'h04,
    ST_OV_DIS = 7'h08,
    ST_HICCUP = 7'h10,
    ST_EXT_OT = 7'h20,
    ST_DIE_OT = 7'h40
  } state_t;

endpackage

// *** tb/fault_seq_monitor.sv ***
// Purpose: Assertion checker on the fault sequencer ports
// Assumes: Soft-start length of 2 ticks written by the bench
// Notes: Bound to the top module after the checker
`timescale 1ns/1ns
module fault_seq_monitor #(
  parameter int HIC_CYC = 1600
) (
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic FB_OV_IN,
  input wire logic LIMIT_RES_PRESENT_IN,
  input wire logic UPPER_EN_OUT,
  input wire logic LOWER_EN_OUT,
  input wire logic LOWER_FORCE_OUT,
  input wire logic PG_OE_N_OUT,
  input wire logic COMP_PULL_OUT,
  input wire logic SS_ACTIVE_OUT,
  input wire logic THRESH_FIXED_OUT,
  input wire buck_fault_pkg::state_t STATE_OUT
);
  import buck_fault_pkg::*;
  // ==========================================================
  // Helper counters
  int ov_run;
  int hic_run;
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN || !FB_OV_IN) begin
      ov_run <= 0;
    end else if (ov_run < 50000) begin
      ov_run <= ov_run + 1;
    end
  end
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN || STATE_OUT != ST_HICCUP) begin
      hic_run <= 0;
    end else begin
      hic_run <= hic_run + 1;
    end
  end
  // ==========================================================
  // Assertions
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  sequence s_ov_held;
    (STATE_OUT == ST_OV_DIS) [*2];
  endsequence
  sequence s_hot_held;
    (STATE_OUT == ST_EXT_OT || STATE_OUT == ST_DIE_OT) [*2];
  endsequence
  a_hiccup_all_off: assert property ($rose(STATE_OUT == ST_HICCUP) |-> ##[0:1]
    (!UPPER_EN_OUT && !LOWER_EN_OUT && !LOWER_FORCE_OUT && !PG_OE_N_OUT))
    else $error("hiccup entered with a switch or flag still on");
  a_hiccup_wait_len: assert property ($fell(STATE_OUT == ST_HICCUP) && STATE_OUT == ST_SOFT
    |-> hic_run >= HIC_CYC - 220 && hic_run <= HIC_CYC + 220)
    else $error("hiccup wait length wrong");
  a_soft_only_oc: assert property (STATE_OUT == ST_SOFT |=>
    STATE_OUT inside {ST_SOFT, ST_RUN, ST_HICCUP, ST_OFF})
    else $error("fault other than current acted in soft-start");
  a_hot_both_off: assert property (s_hot_held |->
    !UPPER_EN_OUT && !LOWER_EN_OUT && !LOWER_FORCE_OUT)
    else $error("switch on during over-temperature");
  a_die_comp_pull: assert property ((STATE_OUT == ST_DIE_OT) [*2] |-> COMP_PULL_OUT)
    else $error("compensation not pulled in die over-temperature");
  a_ov_blank_time: assert property ($rose(STATE_OUT == ST_OV_DIS) |-> ov_run >= 2000)
    else $error("over-voltage fault set before blanking time");
  a_ov_discharge: assert property (s_ov_held |->
    !UPPER_EN_OUT && LOWER_FORCE_OUT && !PG_OE_N_OUT)
    else $error("discharge drive wrong");
  a_soft_flag_low: assert property (SS_ACTIVE_OUT |-> !PG_OE_N_OUT)
    else $error("flag released in soft-start");
  a_flag_only_run: assert property (PG_OE_N_OUT |->
    STATE_OUT == ST_RUN || $past(STATE_OUT) == ST_RUN)
    else $error("flag released outside regulation");
  a_fixed_thresh: assert property ($fell(LIMIT_RES_PRESENT_IN) |-> ##8 THRESH_FIXED_OUT)
    else $error("fixed threshold not selected");
endmodule
bind buck_fault_hiccup_controller fault_seq_monitor #(.HIC_CYC(1600)) mon (
  .CLK_IN, .SYS_RST_IN, .FB_OV_IN, .LIMIT_RES_PRESENT_IN, .UPPER_EN_OUT, .LOWER_EN_OUT,
  .LOWER_FORCE_OUT, .PG_OE_N_OUT, .COMP_PULL_OUT, .SS_ACTIVE_OUT, .THRESH_FIXED_OUT,
  .STATE_OUT
);

// *** tb/gate_driver_model.sv ***
// Purpose: Lower gate driver and current comparator model
// Assumes: Switching period of 200 clocks, gate on in second half
// Notes: One trip pulse per request, starting with the gate rise
`timescale 1ns/1ns
module gate_driver_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic lower_en_in,
  input wire logic lower_force_in,
  input wire logic [1:0] oc_kind_in,
  output logic gate_on_out,
  output logic oc_trip_out
);
  logic [7:0] phase_r;
  logic [6:0] shot_r;
  always_ff @(posedge clk_in) begin
    if (rst_in || phase_r == 8'hc7) begin
      phase_r <= 8'h00;
    end else begin
      phase_r <= phase_r + 8'h01;
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      shot_r <= 7'h00;
    end else if (phase_r == 8'h63 && lower_en_in && oc_kind_in != 2'h0) begin
      shot_r <= (oc_kind_in == 2'h1) ? 7'h0a : 7'h28;
    end else if (shot_r != 7'h00) begin
      shot_r <= shot_r - 7'h01;
    end
  end
  assign gate_on_out = lower_force_in || (lower_en_in && phase_r >= 8'h64);
  assign oc_trip_out = shot_r != 7'h00;
endmodule

// *** tb/buck_fault_hiccup_controller_tb.sv ***
// Purpose: Self-checking bench for the fault sequencer
// Assumes: Gate driver model on the lower switch side
// Notes: Soft-start shortened to 2 ticks over the register bus
`timescale 1ns/1ns
module buck_fault_hiccup_controller_tb;
  import buck_fault_pkg::*;
  logic clk = 1'b0, rst = 1'b1, ov = 1'b0, uv = 1'b0, ext = 1'b0, die = 1'b0, res = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready, err, slv, oc, gate;
  logic up, lo, lof, flag, flag_oe_n, comp, ss, fix;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [1:0] kind = 2'h0;
  state_t st;
  int fails = 0, n_checks = 0, seed = 32'h7100, k, t;
  buck_fault_hiccup_controller uut (
    .CLK_IN(clk), .SYS_RST_IN(rst), .FB_OV_IN(ov), .FB_UV_IN(uv), .LS_OC_IN(oc),
    .EXT_OT_IN(ext), .DIE_OT_IN(die), .LIMIT_RES_PRESENT_IN(res), .LS_GATE_IN(gate),
    .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(err),
    .UPPER_EN_OUT(up), .LOWER_EN_OUT(lo), .LOWER_FORCE_OUT(lof), .PG_OUT(flag),
    .PG_OE_N_OUT(flag_oe_n), .COMP_PULL_OUT(comp), .SS_ACTIVE_OUT(ss),
    .THRESH_FIXED_OUT(fix), .STATE_OUT(st)
  );
  gate_driver_model drv (
    .clk_in(clk), .rst_in(rst), .lower_en_in(lo), .lower_force_in(lof),
    .oc_kind_in(kind), .gate_on_out(gate), .oc_trip_out(oc)
  );
  // ==========================================================
  // Helpers
  function automatic int hic_exp(int ss_len);
    return HICCUP_SS_MULT * ss_len * SW_PERIOD_CYC;
  endfunction
  function automatic state_t hot_st(int i);
    return (i == 0) ? ST_EXT_OT : ST_DIE_OT;
  endfunction
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    rd = prdata;
    slv = err;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
    if (t >= 20) begin
      fails++;
      stop_test();
    end
  endtask
  task automatic wait_st(input state_t s, input int lim);
    t = 0;
    while (st !== s && t < lim) begin
      @(posedge clk);
      t++;
    end
    if (st !== s) begin
      fails++;
      $display("MISMATCH at %0t: state %h not reached", $time, s);
      stop_test();
    end
  endtask
  task automatic trip(input logic [1:0] kd);
    kind <= kd;
    t = 0;
    while (oc !== 1'b1 && t < 400) begin
      @(posedge clk);
      t++;
    end
    kind <= 2'h0;
    repeat (30) @(posedge clk);
    if (kd == 2'h2) begin
      check(up, 1'b0, "upper off during trip");
      check(flag_oe_n, 1'b0, "flag low during trip");
    end
  endtask
  task automatic done(input string name);
    $display("Test %s finished", name);
  endtask
  // ==========================================================
  // Clock, watchdog, sequence
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    stop_test();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check(flag_oe_n, 1'b0, "flag after reset");
    check(flag, 1'b0, "flag drive value");
    apb(1'b0, ADDR_SS_LEN, 32'h0);
    check(rd, 32'(SS_LEN_RST), "soft-start length reset");
    apb(1'b0, 8'h14, 32'h0);
    check(slv, 1'b1, "unmapped error");
    check(rd, 32'h0, "unmapped data");
    apb(1'b1, ADDR_CTRL, 32'h0);
    wait_st(ST_OFF, 10);
    apb(1'b1, ADDR_SS_LEN, 32'h2);
    apb(1'b1, ADDR_CTRL, 32'h1);
    wait_st(ST_SOFT, 10);
    check(flag_oe_n, 1'b0, "flag in soft-start");
    ov <= 1'b1;
    repeat (50 + ($random(seed) & 63)) @(posedge clk);
    ov <= 1'b0;
    wait_st(ST_RUN, 600);
    repeat (10) @(posedge clk);
    check(flag_oe_n, 1'b1, "flag released");
    done("start");
    ov <= 1'b1;
    wait_st(ST_OV_DIS, 2300);
    check(32'(t > 1990), 32'h1, "over-voltage blanking");
    repeat (2) @(posedge clk);
    check({up, lof, flag_oe_n}, 3'h2, "discharge drive");
    repeat (50) @(posedge clk);
    check(st, ST_OV_DIS, "discharge held");
    ov <= 1'b0;
    uv <= 1'b1;
    wait_st(ST_HICCUP, 20);
    repeat (2) @(posedge clk);
    check({up, lo, lof, flag_oe_n}, 4'h0, "all off in hiccup");
    uv <= 1'b0;
    wait_st(ST_SOFT, 2000);
    check(32'(t > hic_exp(2) - 220 && t < hic_exp(2) + 220), 32'h1, "retry wait");
    wait_st(ST_RUN, 600);
    done("over-voltage");
    uv <= 1'b1;
    repeat (1990) @(posedge clk);
    check(st, ST_RUN, "under-voltage blanking");
    wait_st(ST_HICCUP, 300);
    uv <= 1'b0;
    wait_st(ST_SOFT, 2000);
    wait_st(ST_RUN, 600);
    apb(1'b0, ADDR_FAULT, 32'h0);
    check(rd, 32'h3, "sticky voltage faults");
    apb(1'b1, ADDR_FAULT, 32'h1f);
    apb(1'b0, ADDR_FAULT, 32'h0);
    check(rd, 32'h0, "faults cleared");
    done("under-voltage");
    for (k = 0; k < 2; k++) begin
      ext <= (k == 0);
      die <= (k == 1);
      wait_st(hot_st(k), 20);
      repeat (2) @(posedge clk);
      check({up, lo}, 2'h0, "switches off when hot");
      check(comp, 32'(k), "compensation pull");
      ext <= 1'b0;
      die <= 1'b0;
      wait_st(ST_SOFT, 20);
      wait_st(ST_RUN, 600);
    end
    done("temperature");
    res <= 1'b0;
    repeat (10) @(posedge clk);
    check(fix, 1'b1, "fixed threshold");
    res <= 1'b1;
    repeat (10) @(posedge clk);
    check(fix, 1'b0, "resistor threshold");
    done("threshold");
    for (k = 0; k < 3; k++) begin
      trip(2'h1);
    end
    apb(1'b0, ADDR_OC_CNT, 32'h0);
    check(rd[1:0], 2'h0, "blanked trips");
    trip(2'h2);
    repeat (250) @(posedge clk);
    check(up, 1'b1, "upper resumes");
    apb(1'b0, ADDR_OC_CNT, 32'h0);
    check(rd[1:0], 2'h1, "one event");
    repeat (1600) @(posedge clk);
    apb(1'b0, ADDR_OC_CNT, 32'h0);
    check(rd[1:0], 2'h0, "count cleared");
    for (k = 0; k < 3; k++) begin
      trip(2'h2);
      if (k < 2) begin
        repeat (800 + 200 * ($random(seed) & 1)) @(posedge clk);
      end
      if (k == 1) begin
        apb(1'b0, ADDR_OC_CNT, 32'h0);
        check(rd[1:0], 2'h2, "backup restarted");
      end
    end
    wait_st(ST_HICCUP, 300);
    wait_st(ST_SOFT, 2000);
    wait_st(ST_RUN, 600);
    done("over-current");
    stop_test();
  end
endmodule
